// ---- shared/slli_pkg.sv ----
`default_nettype none
package slli_pkg;
	// frame layout: first bit sent is bit 27, last is bit 0
	localparam int FRAME_BITS = 28;
	localparam int WORD_W     = 24;
	localparam int C1_POS     = 27;
	localparam int DCA_POS    = 26;
	localparam int DCB_POS    = 25;
	localparam int DAT_HI     = 24;
	localparam int DAT_LO     = 1;
	localparam int C0_POS     = 0;
	localparam logic [4:0] LAST_PHASE = 5'(FRAME_BITS - 1);
	localparam logic [4:0] PRE_PHASE  = 5'(FRAME_BITS - 2);
	localparam logic [4:0] CLK_HI_END = 5'((FRAME_BITS / 2) - 1);
	// good frames in a row before lock is declared
	localparam int LOCK_CHECKS_DEF = 4;
	// clock rates, one serial bit per ref_clk cycle
	localparam int REF_CLK_MHZ  = 200;
	localparam int WORD_KHZ     = (REF_CLK_MHZ * 1000) / FRAME_BITS;
	localparam int WORD_MIN_KHZ = 3000;
	localparam int WORD_MAX_KHZ = 40000;
	// reset values and receive buffer depth
	localparam logic [23:0] LFSR_SEED = 24'h5A5A5A;
	localparam logic signed [7:0] DISP_RST = 8'sh00;
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	typedef enum logic [3:0] {
		RX_OFF    = 4'h1,
		RX_HUNT   = 4'h2,
		RX_VERIFY = 4'h4,
		RX_LOCK   = 4'h8
	} slli_rx_state_t;

	// serial line, enable low while driven
	typedef struct packed {
		logic out_en_n;
		logic pos;
		logic neg;
	} slli_ser_t;

	// parallel receive pins, enable low while driven
	typedef struct packed {
		logic        out_en_n;
		logic        recovered_clock;
		logic [23:0] parallel_word_outputs;
	} slli_par_t;
endpackage
`default_nettype wire

// ---- rtl/slli_link.sv ----
// Functional notes
// RULE_01: lock indicator high exactly while receive side is locked.
// RULE_02: while unlocked, parallel word and recovered clock outputs are not driven.
// RULE_03: reserved strap must be held low by the board.
// RULE_04: each 24-bit word becomes one serial frame with embedded clock bits.
// RULE_05: received frames are decoded back to 24-bit words with a recovered clock.
// RULE_06: word clock must lie between 3 and 40 MHz inclusive.
// RULE_07: lock is found from the stream alone, for any data pattern.
// RULE_08: serializer locks first; receiver only then synchronises to it.
// RULE_09: without good supply all outputs float and logic stays idle.
// RULE_10: serial outputs float until the transmit PLL is locked.
// RULE_11: receive outputs float while the receiver hunts for lock.
// RULE_12: with no source word, the serializer sends random data.
// RULE_13: receiver expects coded bits and re-times them on its bit clock.
// RULE_14: lock needs a found clock edge plus several integrity checks.
// RULE_15: lock time varies; users must watch the lock indicator.
// RULE_16: lock, first valid word and recovered clock appear together.
// RULE_17: one missed embedded clock edge drops lock and restarts hunting.
// RULE_18: words change only with the recovered clock rising edge.
`timescale 1ns/10ps
`default_nettype none
module slli_link #(
	parameter int LOCK_CHECKS = slli_pkg::LOCK_CHECKS_DEF
) (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 supply_good,
	input  wire logic                 tx_pll_locked,
	input  wire logic [23:0]          tx_word,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	output var slli_pkg::slli_ser_t   ser_out,
	input  wire logic                 serial_input_true,
	input  wire logic                 serial_input_inverted,
	input  wire logic                 receiver_sleep_control,
	input  wire logic                 reserved_strap_input,
	input  wire logic                 word_ready,
	output logic                      lock_indicator,
	output var slli_pkg::slli_par_t   rx_pins,
	output logic                      buf_full
);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	function automatic logic [4:0] ones_of(input logic [23:0] w);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < slli_pkg::WORD_W; i++)
			c = c + 5'(w[i]);
		return c;
	endfunction

	// clock marks and integrity bit of a complete frame
	function automatic logic frame_good(input logic [27:0] f);
		return f[slli_pkg::C1_POS] & ~f[slli_pkg::C0_POS]
			& (f[slli_pkg::DCA_POS] == ^f[slli_pkg::DAT_HI:slli_pkg::DAT_LO]);
	endfunction

	function automatic logic [23:0] decode(input logic [27:0] f);
		return f[slli_pkg::DAT_HI:slli_pkg::DAT_LO] ^ {24{f[slli_pkg::DCB_POS]}};
	endfunction

	////////////////////////////////////////////////////////////////
	// transmit side

	logic               tx_on;
	logic [4:0]         tx_ph_r;
	logic [27:0]        tx_sr_r;
	logic [23:0]        lfsr_r;
	logic signed [7:0]  disp_r;
	logic               tx_load;
	logic               tx_take;
	logic [23:0]        tx_src;
	logic [4:0]         tx_ones;
	logic signed [7:0]  tx_exc;
	logic               tx_inv;
	logic [23:0]        tx_pay;
	logic [27:0]        tx_frame;
	logic signed [7:0]  disp_nxt;

	// RULE_08 serializer first
	// RULE_09 idle without supply
	assign tx_on = supply_good & tx_pll_locked;
	assign tx_load = tx_on & (tx_ph_r == slli_pkg::LAST_PHASE);
	assign tx_take = tx_load & tx_ready & tx_valid;
	// RULE_12 random fill word
	assign tx_src = tx_take ? tx_word : lfsr_r;

	// dc balance: invert when it pulls the running disparity back
	always_comb
	begin
		tx_ones = ones_of(tx_src);
		tx_exc = $signed({3'h0, tx_ones}) - 8'sd12;
		tx_inv = (tx_exc != 8'sd0) && ((disp_r > 8'sd0) == (tx_exc > 8'sd0));
		tx_pay = tx_src ^ {24{tx_inv}};
		disp_nxt = tx_inv ? disp_r - tx_exc : disp_r + tx_exc;
		// RULE_04 frame build
		tx_frame = {1'b1, ^tx_pay, tx_inv, tx_pay, 1'b0};
	end

	// frame phase and shift out, parked on the load phase while off
	always_ff @(posedge ref_clk)
	begin
		if (srst || !tx_on)
		begin
			tx_ph_r <= slli_pkg::LAST_PHASE;
			tx_sr_r <= '0;
		end
		else if (tx_load)
		begin
			tx_ph_r <= 5'h00;
			tx_sr_r <= tx_frame;
		end
		else
		begin
			tx_ph_r <= tx_ph_r + 5'h01;
			tx_sr_r <= {tx_sr_r[26:0], 1'b0};
		end
	end

	// disparity and random source advance once per frame
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			disp_r <= slli_pkg::DISP_RST;
			lfsr_r <= slli_pkg::LFSR_SEED;
		end
		else if (tx_load)
		begin
			disp_r <= disp_nxt;
			lfsr_r <= {lfsr_r[22:0], lfsr_r[23] ^ lfsr_r[22] ^ lfsr_r[21] ^ lfsr_r[16]};
		end
	end

	// ready is high only in the load cycle; a fresh start sends random data
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			tx_ready <= 1'b0;
		else
			tx_ready <= tx_on && (tx_ph_r == slli_pkg::PRE_PHASE);
	end

	// RULE_10 float until locked
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			ser_out <= '{out_en_n: 1'b1, pos: 1'b0, neg: 1'b1};
		else
			ser_out <= '{out_en_n: !tx_on, pos: tx_on & tx_sr_r[27], neg: !(tx_on & tx_sr_r[27])};
	end

	// RULE_10 serial float check
	tx_hold_hiz_a: assert property (!tx_on |=> ser_out.out_en_n) // RULE_10
		else $error("serial line driven before transmit lock");
	// RULE_04 frame marks check
	tx_frame_marks_a: assert property (tx_load ##1 tx_on |-> tx_sr_r[27] && !tx_sr_r[0] // RULE_04
		&& (tx_sr_r[26] == ^tx_sr_r[24:1]))
		else $error("frame clock or integrity bit wrong");
	// RULE_12 random fill check
	tx_random_fill_a: assert property (tx_load && !tx_take ##1 tx_on |-> decode(tx_sr_r) == $past(lfsr_r)) // RULE_12
		else $error("idle frame does not carry the random word");

	////////////////////////////////////////////////////////////////
	// receive acquisition

	slli_pkg::slli_rx_state_t st_r;
	logic          rx_run;
	logic          rx_bit;
	logic [27:0]   sr_r;
	logic [27:0]   sr_nxt;
	logic [4:0]    ph_r;
	logic [3:0]    good_r;
	logic          frame_done;
	logic          rx_ok;
	logic          edge_ok;
	logic [23:0]   rx_word;
	logic          enter_lock;
	logic          drop;
	logic          deliver;

	// RULE_03 strap must be low
	assign rx_run = supply_good & receiver_sleep_control & ~reserved_strap_input;
	// RULE_13 coded bit re-timed
	assign rx_bit = serial_input_true & ~serial_input_inverted;
	assign sr_nxt = {sr_r[26:0], rx_bit};
	assign frame_done = (ph_r == slli_pkg::LAST_PHASE);
	assign rx_ok = frame_good(sr_nxt);
	assign edge_ok = sr_nxt[slli_pkg::C1_POS] & ~sr_nxt[slli_pkg::C0_POS];
	// RULE_05 word rebuilt
	assign rx_word = decode(sr_nxt);
	// RULE_14 edge plus checks
	assign enter_lock = (st_r == slli_pkg::RX_VERIFY) && frame_done && rx_ok
		&& (good_r == 4'(LOCK_CHECKS - 1));
	// RULE_17 single miss drops
	assign drop = (st_r == slli_pkg::RX_LOCK) && frame_done && !edge_ok;
	assign deliver = enter_lock | ((st_r == slli_pkg::RX_LOCK) && frame_done && edge_ok);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			sr_r <= '0;
		else
			sr_r <= sr_nxt;
	end

	// RULE_15 no lock timeout
	// RULE_07 stream-only hunt
	// hunt tests every bit position; no timeout, so lock time follows the data
	always_ff @(posedge ref_clk)
	begin
		if (srst || !rx_run)
			st_r <= slli_pkg::RX_OFF;
		else
			case (st_r)
				slli_pkg::RX_OFF:
					st_r <= slli_pkg::RX_HUNT;
				slli_pkg::RX_HUNT:
					if (rx_ok)
						st_r <= slli_pkg::RX_VERIFY;
				slli_pkg::RX_VERIFY:
					if (frame_done && !rx_ok)
						st_r <= slli_pkg::RX_HUNT;
					else if (enter_lock)
						st_r <= slli_pkg::RX_LOCK;
				slli_pkg::RX_LOCK:
					if (drop)
						st_r <= slli_pkg::RX_HUNT;
				default:
					st_r <= slli_pkg::RX_OFF;
			endcase
	end

	// phase zero means the next bit opens a frame
	always_ff @(posedge ref_clk)
	begin
		if (srst || !rx_run || st_r == slli_pkg::RX_HUNT || frame_done)
			ph_r <= 5'h00;
		else if (st_r != slli_pkg::RX_OFF)
			ph_r <= ph_r + 5'h01;
	end

	// the matching hunt frame counts as the first good one
	always_ff @(posedge ref_clk)
	begin
		if (srst || st_r != slli_pkg::RX_VERIFY)
			good_r <= 4'h1;
		else if (frame_done && rx_ok)
			good_r <= good_r + 4'h1;
	end

	////////////////////////////////////////////////////////////////
	// two-entry buffer with bypass ahead of the output pins

	logic [23:0]  mem_r [2];
	logic         wr_ptr_r;
	logic         rd_ptr_r;
	logic [1:0]   cnt_r;
	logic         take;
	logic         bypass;
	logic         pop;
	logic         push;
	logic [1:0]   cnt_nxt;

	// the first word of a lock goes out even if the user stalls
	assign take = deliver & (word_ready | enter_lock);
	assign bypass = take & (cnt_r == 2'h0);
	assign pop = take & (cnt_r != 2'h0);
	// a word arriving with the buffer full and no pop is lost
	assign push = deliver & !bypass & ((cnt_r != slli_pkg::BUF_DEPTH) | pop);
	assign cnt_nxt = cnt_r + 2'(push) - 2'(pop);

	always_ff @(posedge ref_clk)
	begin
		if (srst || st_r != slli_pkg::RX_LOCK)
		begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r <= 2'h0;
			buf_full <= 1'b0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
			cnt_r <= cnt_nxt;
			buf_full <= (cnt_nxt == slli_pkg::BUF_DEPTH);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= rx_word;
	end

	////////////////////////////////////////////////////////////////
	// output pins

	logic out_off;
	assign out_off = !rx_run || drop || (st_r != slli_pkg::RX_LOCK && !enter_lock);

	// RULE_01 lock follows state
	// RULE_02 float while unlocked
	// RULE_11 float while hunting
	// RULE_16 lock with first word
	// RULE_18 word on clock rise
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			lock_indicator <= 1'b0;
			rx_pins <= '{out_en_n: 1'b1, recovered_clock: 1'b0, parallel_word_outputs: 24'h000000};
		end
		else if (out_off)
		begin
			lock_indicator <= 1'b0;
			rx_pins.out_en_n <= 1'b1;
			rx_pins.recovered_clock <= 1'b0;
		end
		else
		begin
			lock_indicator <= 1'b1;
			rx_pins.out_en_n <= 1'b0;
			rx_pins.recovered_clock <= frame_done | (ph_r < slli_pkg::CLK_HI_END);
			if (take)
				rx_pins.parallel_word_outputs <= bypass ? rx_word : mem_r[rd_ptr_r];
		end
	end

	////////////////////////////////////////////////////////////////
	// receive checks

	logic [7:0] gap_r;

	// cycles since the last recovered clock rise
	always_ff @(posedge ref_clk)
	begin
		if (srst || $rose(rx_pins.recovered_clock))
			gap_r <= 8'h00;
		else if (gap_r != 8'hFF)
			gap_r <= gap_r + 8'h01;
	end

	sequence s_checked;
		st_r == slli_pkg::RX_VERIFY && frame_done && rx_ok;
	endsequence

	sequence s_first_word;
		lock_indicator && !rx_pins.out_en_n && rx_pins.recovered_clock;
	endsequence

	// RULE_06 word rate range
	word_rate_a: assert property (slli_pkg::WORD_KHZ >= slli_pkg::WORD_MIN_KHZ // RULE_06
		&& slli_pkg::WORD_KHZ <= slli_pkg::WORD_MAX_KHZ)
		else $error("word clock outside supported range");
	// RULE_09 supply gating check
	supply_off_a: assert property (!supply_good |=> !lock_indicator && rx_pins.out_en_n // RULE_09
		&& ser_out.out_en_n)
		else $error("outputs active without good supply");
	// RULE_01 lock state check
	lock_state_a: assert property (lock_indicator == (st_r == slli_pkg::RX_LOCK)) // RULE_01
		else $error("lock indicator disagrees with receiver state");
	// RULE_11 float while hunting
	unlock_hiz_a: assert property (!lock_indicator |-> rx_pins.out_en_n && !rx_pins.recovered_clock) // RULE_11
		else $error("receive pins driven while unlocked");
	// RULE_14 lock after checks
	lock_entry_a: assert property (s_checked ##0 (good_r == 4'(LOCK_CHECKS - 1)) |=> s_first_word) // RULE_14
		else $error("lock not taken after the last good check");
	// RULE_16 first word valid
	first_word_a: assert property ($rose(lock_indicator) |-> $rose(rx_pins.recovered_clock) // RULE_16
		&& rx_pins.parallel_word_outputs == $past(rx_word))
		else $error("lock rose without its first word and clock");
	// RULE_17 miss drops lock
	edge_miss_a: assert property (drop |=> !lock_indicator && st_r == slli_pkg::RX_HUNT // RULE_17
		##1 rx_pins.out_en_n)
		else $error("missed clock edge did not drop lock");
	// RULE_18 word stable
	word_hold_a: assert property (!$stable(rx_pins.parallel_word_outputs) |-> $rose(rx_pins.recovered_clock)) // RULE_18
		else $error("word changed away from recovered clock rise");
	// RULE_18 clock period
	rclk_period_a: assert property ($rose(rx_pins.recovered_clock) && $past(lock_indicator) // RULE_18
		|-> gap_r == 8'(slli_pkg::FRAME_BITS - 1))
		else $error("recovered clock period is not one frame");

endmodule // slli_link
`default_nettype wire

// ---- verification/slli_far_ser.sv ----
`timescale 1ns/10ps
`default_nettype none
module slli_far_ser (
	input  wire logic			ref_clk,
	input  wire logic			run,
	input  wire logic			drop_mark,
	input  wire logic			use_fixed,
	input  wire logic [23:0]	fixed_word,
	output logic				line_true,
	output logic				line_inv,
	output logic				frame_go,
	output logic [23:0]			frame_word
);
	logic [27:0]	sr_r;
	logic [4:0]		ph_r;
	logic [23:0]	gen_r;
	logic			act_r;
	logic			idle_r;
	logic			dcb;
	logic [23:0]	pay;

	////////////////////////////////////////////////////////////////
	// free running source
	assign frame_word = use_fixed ? fixed_word : gen_r;
	// crude weight test for balance; the receiver must undo either choice
	assign dcb = $countones(frame_word) > 12;
	assign pay = frame_word ^ {24{dcb}};
	assign frame_go = run && (ph_r == 5'h00);
	// released line rests at the inverse of the last bit, never a clock-like toggle
	assign line_true = act_r ? sr_r[27] : idle_r;
	assign line_inv = ~line_true;

	////////////////////////////////////////////////////////////////
	// start idle so the receiver sees no marks
	initial
	begin
		ph_r = 5'h00;
		act_r = 1'h0;
		idle_r = 1'h0;
		sr_r = 28'h0;
		gen_r = 24'h13579B;
	end

	always @(negedge ref_clk)
	begin
		if (!run)
		begin
			ph_r <= 5'h00;
			act_r <= 1'h0;
		end
		else
		begin
			ph_r <= (ph_r == 5'h1B) ? 5'h00 : ph_r + 5'h01;
			act_r <= 1'h1;
			sr_r <= frame_go ? {~drop_mark, ^pay, dcb, pay, 1'h0} : {sr_r[26:0], 1'h0};
			if (frame_go)
				gen_r <= {gen_r[22:0], gen_r[23] ^ gen_r[22] ^ gen_r[21] ^ gen_r[16]} + 24'h000001;
		end
		if (act_r)
			idle_r <= ~line_true;
	end
endmodule // slli_far_ser
`default_nettype wire

// ---- verification/slli_link_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module slli_link_tb;
	logic					ref_clk;
	logic					srst;
	logic					supply_good;
	logic					tx_pll_locked;
	logic					tx_valid;
	logic					tx_ready;
	logic					rx_on;
	logic					word_ready;
	logic					lock_indicator;
	logic					buf_full;
	logic					run;
	logic					drop_mark;
	logic					use_fixed;
	logic					line_true;
	logic					line_inv;
	logic					frame_go;
	logic					rc_prev;
	logic					lock_prev;
	logic					rdy_at_edge;
	logic [23:0]			tx_word;
	logic [23:0]			fixed_word;
	logic [23:0]			frame_word;
	logic [23:0]			held;
	logic [23:0]			exp_q[$];
	slli_pkg::slli_ser_t	ser_out;
	slli_pkg::slli_par_t	rx_pins;
	int						miscompares;
	int						tests_run;

	////////////////////////////////////////////////////////////////
	// strap held low
	slli_link u_dut (.ref_clk(ref_clk), .srst(srst), .supply_good(supply_good), .tx_pll_locked(tx_pll_locked),
		.tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .ser_out(ser_out),
		.serial_input_true(line_true), .serial_input_inverted(line_inv), .receiver_sleep_control(rx_on),
		.reserved_strap_input(1'h0), .word_ready(word_ready), .lock_indicator(lock_indicator),
		.rx_pins(rx_pins), .buf_full(buf_full));
	slli_far_ser u_far (.ref_clk(ref_clk), .run(run), .drop_mark(drop_mark), .use_fixed(use_fixed),
		.fixed_word(fixed_word), .line_true(line_true), .line_inv(line_inv), .frame_go(frame_go),
		.frame_word(frame_word));

	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask

	task automatic check_b(input string what, input logic exp, input logic got);
		check(what, {23'h0, exp}, {23'h0, got});
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// lock time varies, so poll with a bound rather than wait a fixed span
	task automatic wait_lock(input logic lv, input int lim);
		int n;
		n = 0;
		while (lock_indicator !== lv && n < lim)
		begin
			cyc(1);
			n++;
		end
		check_b("lock level", lv, lock_indicator);
	endtask

	// capture one sent frame; first bit shows one cycle after the load edge
	task automatic tx_frame(input logic [23:0] w, input logic v, output logic [23:0] dec);
		logic [27:0] f;
		int n;
		n = 0;
		tx_word = w;
		tx_valid = v;
		while (tx_ready !== 1'h1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		check_b("tx ready", 1'h1, tx_ready);
		cyc(2);
		// load edge has passed; drop the offer so the next frame is not taken too
		tx_valid = 1'h0;
		for (int i = 27; i >= 0; i--)
		begin
			f[i] = ser_out.pos;
			check_b("line driven", 1'h0, ser_out.out_en_n);
			check_b("line pair", ~ser_out.pos, ser_out.neg);
			cyc(1);
		end
		tx_valid = 1'h0;
		check_b("start mark", 1'h1, f[27]);
		check_b("end mark", 1'h0, f[0]);
		check_b("parity", ^f[24:1], f[26]);
		dec = f[24:1] ^ {24{f[25]}};
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_supply;
		supply_good = 1'h0;
		tx_pll_locked = 1'h1;
		run = 1'h1;
		cyc(200);
		check_b("tx off", 1'h1, ser_out.out_en_n);
		check_b("rx off", 1'h0, lock_indicator);
		run = 1'h0;
		tx_pll_locked = 1'h0;
		supply_good = 1'h1;
		cyc(30);
		check_b("tx float", 1'h1, ser_out.out_en_n);
		tx_pll_locked = 1'h1;
	endtask

	task automatic t_tx;
		logic [23:0] a;
		logic [23:0] b;
		tx_frame(24'hA5C30F, 1'h1, a);
		check("tx word", 24'hA5C30F, a);
		tx_frame(24'hA5C30F, 1'h0, a);
		tx_frame(24'hA5C30F, 1'h0, b);
		check_b("idle varies", 1'h1, a !== b);
		check_b("idle ignores word", 1'h1, a !== 24'hA5C30F);
	endtask

	task automatic t_lock;
		run = 1'h1;
		cyc(84);
		check_b("early lock", 1'h0, lock_indicator);
		wait_lock(1'h1, 300);
		cyc(28 * 6);
	endtask

	// two rises stalled fill both entries; one more would lose a word
	task automatic t_stall;
		word_ready = 1'h0;
		@(posedge rx_pins.recovered_clock);
		@(posedge rx_pins.recovered_clock);
		cyc(4);
		check_b("buffer full", 1'h1, buf_full);
		word_ready = 1'h1;
		cyc(28 * 4);
		check_b("latency kept", 1'h1, buf_full);
	endtask

	task automatic t_drop;
		drop_mark = 1'h1;
		cyc(28);
		drop_mark = 1'h0;
		wait_lock(1'h0, 60);
		cyc(2);
		check_b("buffer flushed", 1'h0, buf_full);
		wait_lock(1'h1, 300);
		cyc(28 * 3);
	endtask

	task automatic t_sleep;
		rx_on = 1'h0;
		cyc(2);
		check_b("sleep lock", 1'h0, lock_indicator);
		cyc(50);
		check_b("sleep float", 1'h1, rx_pins.out_en_n);
		rx_on = 1'h1;
		wait_lock(1'h1, 300);
	endtask

	task automatic t_pattern;
		logic [23:0] pats[2];
		pats = '{24'h000000, 24'hFFFFFF};
		for (int i = 0; i < 2; i++)
		begin
			run = 1'h0;
			wait_lock(1'h0, 60);
			fixed_word = pats[i];
			use_fixed = 1'h1;
			run = 1'h1;
			wait_lock(1'h1, 300);
			cyc(28 * 3);
		end
	endtask

	////////////////////////////////////////////////////////////////
	// word tracker: outputs float while unlocked; the first word of a lock is found in the sent queue, each later one is the next sent
	always @(negedge ref_clk)
	begin
		if (!srst)
		begin
			if (lock_indicator !== 1'h1)
				check_b("float", 1'h1, rx_pins.out_en_n);
			else if (lock_prev !== 1'h1)
			begin
				check_b("clock with lock", 1'h1, rx_pins.recovered_clock);
				check_b("drive with lock", 1'h0, rx_pins.out_en_n);
				while (exp_q.size() > 1 && exp_q[0] !== rx_pins.parallel_word_outputs)
					void'(exp_q.pop_front());
				held = exp_q.pop_front();
				check("first word", held, rx_pins.parallel_word_outputs);
			end
			else
			begin
				if (rx_pins.recovered_clock === 1'h1 && rc_prev !== 1'h1 && rdy_at_edge === 1'h1)
					held = exp_q.pop_front();
				check("word", held, rx_pins.parallel_word_outputs);
			end
		end
		if (frame_go === 1'h1)
			exp_q.push_back(frame_word);
		rc_prev = rx_pins.recovered_clock;
		lock_prev = lock_indicator;
	end

	// a new word is taken only if ready stood high at the rising edge
	always @(posedge ref_clk)
		rdy_at_edge <= word_ready;

	initial
	begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// the whole sequence needs well under a third of this span
	initial
	begin
		#60000;
		miscompares++;
		$display("Error watchdog expected done seen hang");
		final_report();
	end

	initial
	begin
		srst = 1'h1;
		supply_good = 1'h1;
		tx_pll_locked = 1'h0;
		tx_valid = 1'h0;
		tx_word = 24'h0;
		rx_on = 1'h1;
		word_ready = 1'h1;
		run = 1'h0;
		drop_mark = 1'h0;
		use_fixed = 1'h0;
		fixed_word = 24'h0;
		held = 24'h0;
		miscompares = 0;
		tests_run = 0;
		cyc(2);
		srst = 1'h0;
		check_b("word rate", 1'h1, slli_pkg::WORD_KHZ >= slli_pkg::WORD_MIN_KHZ
			&& slli_pkg::WORD_KHZ <= slli_pkg::WORD_MAX_KHZ);
		t_supply();
		t_tx();
		t_lock();
		t_stall();
		t_drop();
		t_sleep();
		t_pattern();
		final_report();
	end
endmodule // slli_link_tb
`default_nettype wire
